// ==== common/otfs_defs.svh ====
// Contract
// - Three output terminals, each with own code
// - Code 00: on in run, off in stop
// - Code 01: on at set speed, not ramping
// - Code 02: on at or above threshold frequency
// - Code 03: on above overload warning current
// - Code 04: on when PID error excessive
// - Code 05: fault held on until cleared
// - Code 06: on only at arrival frequency
// - Code 07: on when torque estimate exceeds level
// - Code 09: on during undervoltage
// - Code 10: on while torque limiting active
// - Code 11: on once run time exceeded
// - Code 12: on once power time exceeded
// - Code 13: on when thermal count exceeds
// - Code 19: on to release the brake
// - Code 20: on when brake error detected
//
// Constants of the output terminal function selector.
// Assumes inclusion by bare name from the package.
`ifndef OTFS_DEFS_SVH
`define OTFS_DEFS_SVH

// Widths
`define OTFS_CODE_W     8
`define OTFS_ADDR_W     8
`define OTFS_DATA_W     32
`define OTFS_NUM_TERM   3
`define OTFS_NUM_EVT    4

// Option codes (decimal codes held in hex)
`define OTFS_CODE_RUN   8'h00
`define OTFS_CODE_CSPD  8'h01
`define OTFS_CODE_OVRF  8'h02
`define OTFS_CODE_OLW   8'h03
`define OTFS_CODE_PIDE  8'h04
`define OTFS_CODE_FLT   8'h05
`define OTFS_CODE_SETF  8'h06
`define OTFS_CODE_TQL   8'h07
`define OTFS_CODE_UV    8'h09
`define OTFS_CODE_TLIM  8'h0A
`define OTFS_CODE_RUNH  8'h0B
`define OTFS_CODE_PWRH  8'h0C
`define OTFS_CODE_THW   8'h0D
`define OTFS_CODE_BRK   8'h13
`define OTFS_CODE_BERR  8'h14

// Register byte offsets
`define OTFS_ADDR_SEL0  8'h00
`define OTFS_ADDR_SEL1  8'h04
`define OTFS_ADDR_SEL2  8'h08
`define OTFS_ADDR_TERM  8'h0C
`define OTFS_ADDR_STAT  8'h10
`define OTFS_ADDR_CLR   8'h14
`define OTFS_ADDR_IEN   8'h18
`define OTFS_ADDR_FCLR  8'h1C

// Reset values
`define OTFS_SEL0_RST   8'h00
`define OTFS_SEL1_RST   8'h01
`define OTFS_SEL2_RST   8'h05
`define OTFS_IEN_RST    4'h0

// Field positions
`define OTFS_EVT_FLT    3
`define OTFS_FCLR_BIT   0

`endif

// ==== common/otfs_pkg.sv ====
// Types of the output terminal function selector.
// Assumes the constants header is on the include path.
`include "otfs_defs.svh"

package otfs_pkg;

  // Option code as stored per terminal
  typedef logic [`OTFS_CODE_W-1:0] otfs_code_t;

  // Supported output functions
  typedef enum logic [`OTFS_CODE_W-1:0] {
    FN_RUN  = `OTFS_CODE_RUN,
    FN_CSPD = `OTFS_CODE_CSPD,
    FN_OVRF = `OTFS_CODE_OVRF,
    FN_OLW  = `OTFS_CODE_OLW,
    FN_PIDE = `OTFS_CODE_PIDE,
    FN_FLT  = `OTFS_CODE_FLT,
    FN_SETF = `OTFS_CODE_SETF,
    FN_TQL  = `OTFS_CODE_TQL,
    FN_UV   = `OTFS_CODE_UV,
    FN_TLIM = `OTFS_CODE_TLIM,
    FN_RUNH = `OTFS_CODE_RUNH,
    FN_PWRH = `OTFS_CODE_PWRH,
    FN_THW  = `OTFS_CODE_THW,
    FN_BRK  = `OTFS_CODE_BRK,
    FN_BERR = `OTFS_CODE_BERR
  } otfs_func_e;

endpackage

// ==== rtl/otfs_top.sv ====
// Output terminal function selector: three logical output
// terminals, each reporting one drive condition picked by
// its option code register.
// Assumes all condition flags come from drive core logic on
// clk, so none of them is synchronised here.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Constants are taken from the guarded header, so order of
// compilation units does not matter.
`include "otfs_defs.svh"

module otfs_top
  import otfs_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Register port
  input  wire logic [`OTFS_ADDR_W-1:0] regAddr,
  input  wire logic [`OTFS_DATA_W-1:0] regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [`OTFS_DATA_W-1:0] regRdata,
  // Drive core conditions
  input  wire logic                    runModeFlag,
  input  wire logic                    atSpeedConstantFlag,
  input  wire logic                    overFreqArrivalFlag,
  input  wire logic                    setFreqArrivalFlag,
  input  wire logic                    currentWarnFlag,
  input  wire logic                    pidErrorExcessFlag,
  input  wire logic                    faultEvent,
  input  wire logic                    faultClear,
  input  wire logic                    torqueLevelFlag,
  input  wire logic                    supplyLowFlag,
  input  wire logic                    torqueLimitingFlag,
  input  wire logic                    runHoursExpiredFlag,
  input  wire logic                    powerHoursExpiredFlag,
  input  wire logic                    thermalWarningFlag,
  input  wire logic                    brakeReleaseCmd,
  input  wire logic                    brakeFaultFlag,
  // Terminals and status
  output logic      [`OTFS_NUM_TERM-1:0] termOut,
  output logic                         faultLatchedFlag,
  output logic                         irq
);

  localparam int NT = `OTFS_NUM_TERM;
  localparam int NE = `OTFS_NUM_EVT;

  // Option code per terminal
  otfs_code_t          selQ [NT];
  // Selected condition per terminal
  logic [NT-1:0]       condD;
  // Registered terminal levels
  logic [NT-1:0]       termQ;
  // Latched fault
  logic                faultQ;
  // Sticky event status and enables
  logic [NE-1:0]       statQ;
  logic [NE-1:0]       statD;
  logic [NE-1:0]       ienQ;
  logic [NE-1:0]       evt;
  // Read data register
  logic [`OTFS_DATA_W-1:0] rdataQ;
  // Write decodes
  logic                wrClr;
  logic                wrFclr;

  assign wrClr  = regWr && (regAddr == `OTFS_ADDR_CLR);
  assign wrFclr = regWr && (regAddr == `OTFS_ADDR_FCLR)
                  && regWdata[`OTFS_FCLR_BIT];

  // Fault latch: a new fault beats a clear in the same cycle
  // so an alarm is never lost between clear and occurrence.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      faultQ <= 1'b0;
    end else if (faultEvent) begin
      faultQ <= 1'b1;
    end else if (faultClear || wrFclr) begin
      faultQ <= 1'b0;
    end
  end

  // One selector, option register and output flop per terminal
  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : gTerm
      // Byte address of this terminal's option register
      localparam logic [`OTFS_ADDR_W-1:0] SelAddr =
        (g == 0) ? `OTFS_ADDR_SEL0 :
        (g == 1) ? `OTFS_ADDR_SEL1 : `OTFS_ADDR_SEL2;
      localparam otfs_code_t SelRst =
        (g == 0) ? `OTFS_SEL0_RST :
        (g == 1) ? `OTFS_SEL1_RST : `OTFS_SEL2_RST;

      // Option code register, written independently
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          selQ[g] <= SelRst;
        end else if (regWr && (regAddr == SelAddr)) begin
          selQ[g] <= regWdata[`OTFS_CODE_W-1:0];
        end
      end

      // Condition mux; core flags already carry ramp and
      // threshold qualification, so each code is one wire.
      always_comb begin
        case (otfs_func_e'(selQ[g]))
          FN_RUN:  condD[g] = runModeFlag;
          FN_CSPD: condD[g] = atSpeedConstantFlag;
          FN_OVRF: condD[g] = overFreqArrivalFlag;
          FN_OLW:  condD[g] = currentWarnFlag;
          FN_PIDE: condD[g] = pidErrorExcessFlag;
          FN_FLT:  condD[g] = faultQ;
          FN_SETF: condD[g] = setFreqArrivalFlag;
          FN_TQL:  condD[g] = torqueLevelFlag;
          FN_UV:   condD[g] = supplyLowFlag;
          FN_TLIM: condD[g] = torqueLimitingFlag;
          FN_RUNH: condD[g] = runHoursExpiredFlag;
          FN_PWRH: condD[g] = powerHoursExpiredFlag;
          FN_THW:  condD[g] = thermalWarningFlag;
          FN_BRK:  condD[g] = brakeReleaseCmd;
          FN_BERR: condD[g] = brakeFaultFlag;
          // Unsupported codes drive nothing
          default: condD[g] = 1'b0;
        endcase
      end

      // Terminal flop, refreshed every cycle
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          termQ[g] <= 1'b0;
        end else begin
          termQ[g] <= condD[g];
        end
      end
    end
  endgenerate

  // Events: each terminal turning on, and a fault latching
  assign evt = {faultEvent & ~faultQ, condD & ~termQ};

  // Sticky status; an event wins over a clear in one cycle
  always_comb begin
    statD = statQ;
    if (wrClr) begin
      statD = statD & ~regWdata[NE-1:0];
    end
    statD = statD | evt;
  end

  // Status register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statQ <= '0;
    end else begin
      statQ <= statD;
    end
  end

  // Interrupt enable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ienQ <= `OTFS_IEN_RST;
    end else if (regWr && (regAddr == `OTFS_ADDR_IEN)) begin
      ienQ <= regWdata[NE-1:0];
    end
  end

  // Read data: valid only in the cycle after the strobe.
  // Unmapped and write-only offsets read as zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdataQ <= '0;
    end else if (regRd) begin
      case (regAddr)
        `OTFS_ADDR_SEL0: rdataQ <= {24'h000000, selQ[0]};
        `OTFS_ADDR_SEL1: rdataQ <= {24'h000000, selQ[1]};
        `OTFS_ADDR_SEL2: rdataQ <= {24'h000000, selQ[2]};
        `OTFS_ADDR_TERM: rdataQ <= {28'h0000000, faultQ, termQ};
        `OTFS_ADDR_STAT: rdataQ <= {28'h0000000, statQ};
        `OTFS_ADDR_IEN:  rdataQ <= {28'h0000000, ienQ};
        default:         rdataQ <= '0;
      endcase
    end else begin
      rdataQ <= '0;
    end
  end

  // Outputs
  assign regRdata         = rdataQ;
  assign termOut          = termQ;
  assign faultLatchedFlag = faultQ;
  assign irq              = |(statQ & ienQ);

  // Checks on terminal behaviour and the status path
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  run_select_a: assert property (
    $past(selQ[0]) == FN_RUN |-> termQ[0] == $past(runModeFlag))
    else $error("run code does not follow run mode");

  speed_select_a: assert property (
    $past(selQ[1]) == FN_CSPD
      |-> termQ[1] == $past(atSpeedConstantFlag))
    else $error("constant speed code mismatch");

  overfreq_select_a: assert property (
    $past(selQ[0]) == FN_OVRF
      |-> termQ[0] == $past(overFreqArrivalFlag))
    else $error("over frequency code mismatch");

  fault_hold_a: assert property (
    faultEvent |=> faultQ ##1 (faultQ || $past(faultClear)
                               || $past(wrFclr)))
    else $error("fault not held after occurrence");

  fault_term_a: assert property (
    selQ[2] == FN_FLT && $stable(selQ[2])
      |-> termQ[2] == $past(faultQ))
    else $error("fault terminal wrong");

  setfreq_select_a: assert property (
    $past(selQ[1]) == FN_SETF
      |-> termQ[1] == $past(setFreqArrivalFlag))
    else $error("set frequency code mismatch");

  brake_select_a: assert property (
    $past(selQ[0]) == FN_BRK |-> termQ[0] == $past(brakeReleaseCmd))
    else $error("brake release code mismatch");

  brake_err_a: assert property (
    $past(selQ[2]) == FN_BERR |-> termQ[2] == $past(brakeFaultFlag))
    else $error("brake error code mismatch");

  unknown_code_a: assert property (
    $past(selQ[0]) == 8'hFF |-> !termQ[0])
    else $error("unsupported code drove terminal");

  reset_off_a: assert property (
    @(posedge clk) disable iff (1'b0) rst |-> termQ == '0)
    else $error("terminal on during reset");

  event_wins_a: assert property (
    evt[0] && wrClr |=> statQ[0])
    else $error("event lost to clear");

  // An enabled event must raise the interrupt one cycle later
  irq_level_a: assert property (
    evt[0] && ienQ[0] && !regWr |=> irq)
    else $error("enabled event did not raise interrupt");

  // A set status bit only drops through the clear register
  stat_sticky_a: assert property (
    statQ[0] && !wrClr |=> statQ[0])
    else $error("status bit dropped without clear");

  // Terminal 0 sees every code in the bench sweep, so the
  // remaining functions are checked on that terminal.
  current_warn_a: assert property (
    $past(selQ[0]) == FN_OLW |-> termQ[0] == $past(currentWarnFlag))
    else $error("current warning code mismatch");

  pid_error_a: assert property (
    $past(selQ[0]) == FN_PIDE
      |-> termQ[0] == $past(pidErrorExcessFlag))
    else $error("pid error code mismatch");

  torque_level_a: assert property (
    $past(selQ[0]) == FN_TQL |-> termQ[0] == $past(torqueLevelFlag))
    else $error("torque level code mismatch");

  supply_low_a: assert property (
    $past(selQ[0]) == FN_UV |-> termQ[0] == $past(supplyLowFlag))
    else $error("undervoltage code mismatch");

  torque_limit_a: assert property (
    $past(selQ[0]) == FN_TLIM
      |-> termQ[0] == $past(torqueLimitingFlag))
    else $error("torque limiting code mismatch");

  run_hours_a: assert property (
    $past(selQ[0]) == FN_RUNH
      |-> termQ[0] == $past(runHoursExpiredFlag))
    else $error("run hours code mismatch");

  power_hours_a: assert property (
    $past(selQ[0]) == FN_PWRH
      |-> termQ[0] == $past(powerHoursExpiredFlag))
    else $error("power hours code mismatch");

  thermal_warn_a: assert property (
    $past(selQ[0]) == FN_THW
      |-> termQ[0] == $past(thermalWarningFlag))
    else $error("thermal warning code mismatch");

  fault_seen_c: cover property ($rose(faultQ) ##[1:8] $fell(faultQ));
  run_toggle_c: cover property ($rose(termQ[0]) ##[1:8] $fell(termQ[0]));
  irq_seen_c:   cover property ($rose(irq));
  brake_err_c:  cover property (termQ[2] && selQ[2] == FN_BERR);
  clr_race_c:   cover property (evt[0] && wrClr);

endmodule

`default_nettype wire

// ==== verification/otfs_ext_equip.sv ====
// Control equipment wired to the three terminals.
// Assumes terminal levels are registered on clk.
`timescale 1ns/10ps
`default_nettype none
module otfs_ext_equip (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Terminal levels and sticky record
  input  wire logic [2:0] termOut,
  output logic      [2:0] seenOnQ
);
  // Relays only note that a terminal ever closed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seenOnQ <= 3'h0;
    end else begin
      seenOnQ <= seenOnQ | termOut;
    end
  end
endmodule
`default_nettype wire

// ==== verification/otfs_tb.sv ====
// Self-checking bench of the output terminal selector.
// Assumes the package and the equipment model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module output_terminal_function_select_tb_top;
  import otfs_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdata;
  logic [31:0] rdVal;
  logic [13:0] fl = 14'h0;
  logic [13:0] prevFl;
  logic        fEvt = 1'b0;
  logic        fClr = 1'b0;
  logic [2:0]  termOut;
  logic [2:0]  seenOn;
  logic [2:0]  expT;
  logic        faultLatchedFlag;
  logic        irq;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;
  int          seed = 50266;
  // Supported codes in flag order, then latch and unsupported codes
  otfs_code_t  tab [19] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06,
    8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h13, 8'h14,
    8'h05, 8'h08, 8'h0E, 8'h15, 8'hFF};

  always #25 clk = ~clk;

  otfs_top uut (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .runModeFlag(fl[0]),
    .atSpeedConstantFlag(fl[1]), .overFreqArrivalFlag(fl[2]),
    .currentWarnFlag(fl[3]), .pidErrorExcessFlag(fl[4]),
    .setFreqArrivalFlag(fl[5]), .torqueLevelFlag(fl[6]),
    .supplyLowFlag(fl[7]), .torqueLimitingFlag(fl[8]),
    .runHoursExpiredFlag(fl[9]), .powerHoursExpiredFlag(fl[10]),
    .thermalWarningFlag(fl[11]), .brakeReleaseCmd(fl[12]),
    .brakeFaultFlag(fl[13]), .faultEvent(fEvt), .faultClear(fClr),
    .termOut(termOut), .faultLatchedFlag(faultLatchedFlag), .irq(irq));

  otfs_ext_equip equip (.clk(clk), .rst(rst), .termOut(termOut),
    .seenOnQ(seenOn));

  // Condition picked by a code; latch stays clear where this is used
  function automatic logic expCond(otfs_code_t c, logic [13:0] f);
    for (int i = 0; i < 14; i++) if (c === tab[i]) return f[i];
    return 1'b0;
  endfunction

  task automatic chkW(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rdVal = regRdata;
  endtask

  task automatic pulse(logic e, logic c);
    @(posedge clk);
    fEvt <= e;
    fClr <= c;
    @(posedge clk);
    fEvt <= 1'b0;
    fClr <= 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    // Raised as an event so the asynchronous resets act at once
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    chkW({29'h0, termOut}, 32'h0);
    rst <= 1'b0;
    rd(8'h00);
    chkW(rdVal, 32'h0);
    rd(8'h04);
    chkW(rdVal, 32'h1);
    rd(8'h08);
    chkW(rdVal, 32'h5);
    rd(8'h20);
    chkW(rdVal, 32'h0);
    // Every code on every terminal, random conditions
    for (int p = 0; p < 19; p++) begin
      wr(8'h00, {24'h0, tab[p]});
      wr(8'h04, {24'h0, tab[(p + 6) % 19]});
      wr(8'h08, {24'h0, tab[(p + 13) % 19]});
      for (int k = 0; k < 12; k++) begin
        @(posedge clk);
        prevFl = fl;
        fl <= 14'($random(seed));
        @(negedge clk);
        expT = {expCond(tab[(p + 13) % 19], prevFl),
          expCond(tab[(p + 6) % 19], prevFl), expCond(tab[p], prevFl)};
        chkW(32'(termOut[0]), 32'(expT[0]));
        chkW(32'(termOut[1]), 32'(expT[1]));
        chkW(32'(termOut[2]), 32'(expT[2]));
      end
    end
    // Fault latch held until cleared, by pin and by register
    @(posedge clk);
    fl <= 14'h0;
    wr(8'h08, 32'h5);
    pulse(1'b1, 1'b0);
    rd(8'h0C);
    chkW(rdVal, 32'hC);
    pulse(1'b0, 1'b1);
    chkW({29'h0, termOut}, 32'h0);
    pulse(1'b1, 1'b1);
    chkW({31'h0, faultLatchedFlag}, 32'h1);
    wr(8'h1C, 32'h1);
    repeat (2) @(negedge clk);
    chkW({28'h0, faultLatchedFlag, termOut}, 32'h0);
    // Interrupt raised, held, cleared and masked
    wr(8'h00, 32'h0);
    wr(8'h14, 32'hF);
    wr(8'h18, 32'h1);
    rd(8'h18);
    chkW({rdVal[30:0], irq}, 32'h2);
    @(posedge clk);
    fl <= 14'h1;
    repeat (3) @(posedge clk);
    fl <= 14'h0;
    rd(8'h10);
    chkW({rdVal[0], 30'h0, irq}, 32'h80000001);
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h0);
    @(posedge clk);
    fl <= 14'h1;
    repeat (3) @(negedge clk);
    chkW({31'h0, irq}, 32'h0);
    // Terminal rising in the very cycle of a status clear
    @(posedge clk);
    fl <= 14'h0;
    repeat (2) @(posedge clk);
    fl <= 14'h1;
    regAddr <= 8'h14;
    regWdata <= 32'h1;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    rd(8'h10);
    chkW(rdVal, 32'h1);
    chkW({29'h0, seenOn}, 32'h7);
    print_verdict();
  end
endmodule
`default_nettype wire
